//--- design/uart_host_params.svh
// Register offsets, field positions and reset values of the host select block.
// Assumes it is included by its bare name from the design package and module.
`ifndef UART_HOST_PARAMS_SVH
`define UART_HOST_PARAMS_SVH

`define ADDR_DLL_SEL     3'h0
`define ADDR_DLM_IER     3'h1
`define ADDR_LCR         3'h3
`define ADDR_MCR         3'h4
`define ADDR_MSR         3'h6
`define ADDR_SCR         3'h7

`define LCR_WLS_LO       0
`define LCR_WLS_HI       1
`define LCR_PEN          3
`define LCR_EPS          4
`define LCR_DLAB         7
`define IER_MSI          3
`define MCR_AUTO_CTS     5
`define MSR_DCTS         0
`define MSR_CTS          4

`define REG_RESET        8'h00
`define DIV_RESET        16'h0000
`define PIN_BUNDLE_W     18

`endif

//--- design/uart_host_pkg.sv
// Types shared by the host select block.
// Assumes the constants header sits beside it.
`include "uart_host_params.svh"

package uart_host_pkg;
    typedef logic [2:0]  reg_addr_t;
    typedef logic [7:0]  byte_t;
    typedef logic [15:0] divisor_t;
    typedef logic [1:0]  word_len_t;
endpackage

//--- design/uart_host_select.sv
// Host register select, data bus, rate clock and clear-to-send logic of a UART.
// Assumes all host pins and the clear-to-send pin are asynchronous to mclk_i.
`timescale 1ns/1ps
`include "uart_host_params.svh"

module uart_host_select (
    input  wire logic                   mclk_i,
    input  wire logic                   resetn_i,
    input  wire logic [2:0]             register_select_lines_i,
    input  wire logic                   select_latch_strobe_n_i,
    input  wire logic                   chip_select_high_a_i,
    input  wire logic                   chip_select_high_b_i,
    input  wire logic                   chip_select_low_n_i,
    input  wire logic                   host_read_n_i,
    input  wire logic                   host_write_n_i,
    input  wire logic [7:0]             host_data_bus_i,
    output logic [7:0]                  host_data_bus_o,
    output logic                        host_data_bus_oe_o,
    input  wire logic                   cts_n_i,
    input  wire logic [7:0]             tx_char_i,
    output logic                        tx_rate_clock_out_o,
    output logic                        tx_rate_tick_o,
    output logic                        tx_enable_o,
    output logic                        modem_int_o,
    output logic [1:0]                  char_len_sel_o,
    output logic                        parity_enable_o,
    output logic                        parity_even_o,
    output logic                        parity_bit_o
);

    logic [`PIN_BUNDLE_W-1:0]  pins_meta_r;
    logic [`PIN_BUNDLE_W-1:0]  pins_sync_r;
    logic [5:0]                sel_hold_r;
    logic                      strobe_prev_r;
    logic                      rd_prev_r;
    logic                      wr_prev_r;
    logic                      cts_prev_r;
    uart_host_pkg::byte_t      ier_r;
    uart_host_pkg::byte_t      lcr_r;
    uart_host_pkg::byte_t      mcr_r;
    uart_host_pkg::byte_t      scr_r;
    uart_host_pkg::byte_t      rdata_r;
    uart_host_pkg::divisor_t   div_r;
    uart_host_pkg::divisor_t   cnt_r;
    logic                      dcts_r;
    logic                      oe_r;
    logic                      rate_clk_r;
    logic                      tick_r;

    // Two-flop synchronisation of every host and modem pin.
    wire [`PIN_BUNDLE_W-1:0] pins_raw = {cts_n_i, host_data_bus_i, host_write_n_i,
        host_read_n_i, select_latch_strobe_n_i, chip_select_low_n_i,
        chip_select_high_b_i, chip_select_high_a_i, register_select_lines_i};

    wire [5:0]               sel_cur  = pins_sync_r[5:0];
    wire                     strobe_s = pins_sync_r[6];
    wire                     rd_n_s   = pins_sync_r[7];
    wire                     wr_n_s   = pins_sync_r[8];
    wire [7:0]               wdata_s  = pins_sync_r[16:9];
    wire                     cts_n_s  = pins_sync_r[17];

    // Transparent while the strobe is low, held after its rising edge.
    wire                     strobe_hold = strobe_s & strobe_prev_r;
    wire [5:0]               sel_eff  = strobe_hold ? sel_hold_r : sel_cur;
    wire                     strobe_rise = strobe_s & ~strobe_prev_r;
    uart_host_pkg::reg_addr_t addr;
    assign addr = sel_eff[2:0];
    wire                     selected = sel_eff[3] & sel_eff[4] & ~sel_eff[5];

    wire                     rd_go = ~rd_n_s & rd_prev_r & selected;
    wire                     wr_go = ~wr_n_s & wr_prev_r & selected;
    wire                     dlab  = lcr_r[`LCR_DLAB];

    wire                     cts_chg  = cts_n_s ^ cts_prev_r;
    wire                     msr_read = rd_go & (addr == `ADDR_MSR);
    logic [7:0]              msr_val;
    always_comb begin
        msr_val             = `REG_RESET;
        msr_val[`MSR_CTS]   = ~cts_n_s;
        msr_val[`MSR_DCTS]  = dcts_r;
    end

    wire                     wr_dll = wr_go & dlab & (addr == `ADDR_DLL_SEL);
    wire                     wr_dlm = wr_go & dlab & (addr == `ADDR_DLM_IER);
    wire                     wr_ier = wr_go & ~dlab & (addr == `ADDR_DLM_IER);
    wire                     wr_lcr = wr_go & (addr == `ADDR_LCR);
    wire                     wr_mcr = wr_go & (addr == `ADDR_MCR);
    wire                     wr_scr = wr_go & (addr == `ADDR_SCR);

    logic [7:0] rd_mux;
    always_comb begin
        case (addr)
            `ADDR_DLL_SEL: rd_mux = dlab ? div_r[7:0] : `REG_RESET;
            `ADDR_DLM_IER: rd_mux = dlab ? div_r[15:8] : ier_r;
            `ADDR_LCR:     rd_mux = lcr_r;
            `ADDR_MCR:     rd_mux = mcr_r;
            `ADDR_MSR:     rd_mux = msr_val;
            `ADDR_SCR:     rd_mux = scr_r;
            default:       rd_mux = `REG_RESET;
        endcase
    end

    // Rate divider: one tick every divisor cycles; zero stops it.
    wire                     div_on   = (div_r != `DIV_RESET);
    wire                     cnt_last = (cnt_r == div_r - 16'h0001);
    wire                     clk_high = (cnt_r < {1'b0, div_r[15:1]});

    wire                     auto_cts = mcr_r[`MCR_AUTO_CTS];
    wire [7:0]               len_mask = 8'hff >> (2'h3 - lcr_r[`LCR_WLS_HI:`LCR_WLS_LO]);

    assign host_data_bus_o     = rdata_r;
    assign host_data_bus_oe_o  = oe_r;
    assign tx_rate_clock_out_o = rate_clk_r;
    assign tx_rate_tick_o      = tick_r;
    assign tx_enable_o         = ~auto_cts | ~cts_n_s;
    assign modem_int_o         = ier_r[`IER_MSI] & dcts_r & ~auto_cts;
    assign char_len_sel_o      = lcr_r[`LCR_WLS_HI:`LCR_WLS_LO];
    assign parity_enable_o     = lcr_r[`LCR_PEN];
    assign parity_even_o       = lcr_r[`LCR_EPS];
    assign parity_bit_o        = lcr_r[`LCR_PEN] & (^(tx_char_i & len_mask) ^ ~lcr_r[`LCR_EPS]);

    always_ff @(posedge mclk_i) begin
        pins_meta_r <= pins_raw;
        pins_sync_r <= pins_meta_r;
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            sel_hold_r    <= 6'h00;
            strobe_prev_r <= 1'b0;
            rd_prev_r     <= 1'b1;
            wr_prev_r     <= 1'b1;
        end else begin
            if (strobe_rise) begin
                sel_hold_r <= sel_cur;
            end
            strobe_prev_r <= strobe_s;
            rd_prev_r     <= rd_n_s;
            wr_prev_r     <= wr_n_s;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            ier_r <= `REG_RESET;
            lcr_r <= `REG_RESET;
            mcr_r <= `REG_RESET;
            scr_r <= `REG_RESET;
            div_r <= `DIV_RESET;
        end else begin
            if (wr_dll) div_r[7:0]  <= wdata_s;
            if (wr_dlm) div_r[15:8] <= wdata_s;
            if (wr_ier) ier_r <= wdata_s;
            if (wr_lcr) lcr_r <= wdata_s;
            if (wr_mcr) mcr_r <= wdata_s;
            if (wr_scr) scr_r <= wdata_s;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            rdata_r <= `REG_RESET;
            oe_r    <= 1'b0;
        end else begin
            if (rd_go) rdata_r <= rd_mux;
            oe_r <= rd_go | (oe_r & ~rd_n_s & selected);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            cts_prev_r <= 1'b1;
            dcts_r     <= 1'b0;
        end else begin
            cts_prev_r <= cts_n_s;
            dcts_r     <= cts_chg | (dcts_r & ~msr_read);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            cnt_r      <= `DIV_RESET;
            tick_r     <= 1'b0;
            rate_clk_r <= 1'b0;
        end else if (!div_on || cnt_last || cnt_r >= div_r) begin
            cnt_r      <= `DIV_RESET;
            tick_r     <= div_on;
            rate_clk_r <= 1'b0;
        end else begin
            cnt_r      <= cnt_r + 16'h0001;
            tick_r     <= 1'b0;
            rate_clk_r <= clk_high;
        end
    end

    // Checking logic.
    uart_host_pkg::divisor_t gap_r;
    logic                    gap_ok_r;
    always_ff @(posedge mclk_i) begin
        if (!resetn_i || wr_dll || wr_dlm) begin
            gap_r    <= `DIV_RESET;
            gap_ok_r <= 1'b0;
        end else if (tick_r) begin
            gap_r    <= `DIV_RESET;
            gap_ok_r <= 1'b1;
        end else begin
            gap_r    <= gap_r + 16'h0001;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_read_start;
        rd_go;
    endsequence
    sequence s_bus_driven;
        host_data_bus_oe_o && host_data_bus_o == $past(rd_mux);
    endsequence

    a_select_pass: assert property (!strobe_s |-> sel_eff == sel_cur)
        else $error("select lines not transparent while strobe low");
    a_select_hold: assert property (strobe_s && $past(strobe_s) |=>
        (strobe_s |-> sel_eff == $past(sel_eff)))
        else $error("select lines changed while strobe high");
    a_drive_gated: assert property (host_data_bus_oe_o |-> $past(selected) && !$past(rd_n_s))
        else $error("data bus driven outside a selected read");
    a_read_drives: assert property (s_read_start |=> s_bus_driven)
        else $error("selected read did not drive the data bus");
    a_cts_delta: assert property (cts_chg |=> dcts_r ##0 msr_val[`MSR_DCTS])
        else $error("clear-to-send change not flagged");
    a_cts_level: assert property (msr_read |=> host_data_bus_o[`MSR_CTS] == !$past(cts_n_s))
        else $error("status does not show clear-to-send level");
    a_int_gate: assert property (modem_int_o |-> !auto_cts && ier_r[`IER_MSI])
        else $error("modem interrupt raised while gated");
    a_tx_gate: assert property (auto_cts && cts_n_s |-> !tx_enable_o)
        else $error("transmitter enabled with clear-to-send inactive");
    a_rate_period: assert property (tick_r && gap_ok_r && $stable(div_r) |->
        gap_r == div_r - 16'h0001)
        else $error("rate tick spacing differs from divisor");
    a_parity_none: assert property (!parity_enable_o |-> !parity_bit_o)
        else $error("parity bit set with parity off");

endmodule

//--- tb/host_cpu_model.sv
// Host processor model that drives the parallel register bus pins.
// Assumes mclk_i runs freely; every pin but wdata_o changes at its falling edge; wdata_o follows oe_i and rdata_i.
`timescale 1ns/1ps

module host_cpu_model (
    input  wire logic       mclk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       oe_i,
    output logic [2:0]      addr_o,
    output logic            strobe_n_o,
    output logic [2:0]      cs_o,
    output logic            rd_n_o,
    output logic            wr_n_o,
    output logic [7:0]      wdata_o
);
    logic [7:0] wd = 8'h00;
    logic       drv = 1'b0;
    // A released bus shows the inverse of the last value, not a stale copy.
    assign wdata_o = oe_i ? rdata_i : (drv ? wd : ~wd);
    initial begin
        addr_o = 3'h0;
        strobe_n_o = 1'b0;
        cs_o = 3'b001;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
    end
    task automatic wr(input logic [2:0] a, input logic [2:0] c, input logic [7:0] v);
        @(negedge mclk_i);
        addr_o = a;
        cs_o = c;
        wd = v;
        drv = 1'b1;
        wr_n_o = 1'b0;
        repeat (4) @(negedge mclk_i);
        wr_n_o = 1'b1;
        repeat (3) @(negedge mclk_i);
        drv = 1'b0;
        repeat (2) @(negedge mclk_i);
    endtask
    task automatic rd(input logic [2:0] a, input logic [2:0] c,
                      output logic [7:0] v, output logic s);
        @(negedge mclk_i);
        addr_o = a;
        cs_o = c;
        rd_n_o = 1'b0;
        s = 1'b0;
        v = 8'h00;
        for (int n = 0; n < 8 && !s; n++) begin
            @(negedge mclk_i);
            s = (oe_i === 1'b1);
        end
        if (s)
            v = rdata_i;
        rd_n_o = 1'b1;
        repeat (4) @(negedge mclk_i);
    endtask
    task automatic hold_sel(input logic [2:0] a, input logic [2:0] c);
        @(negedge mclk_i);
        addr_o = a;
        cs_o = c;
        repeat (3) @(negedge mclk_i);
        strobe_n_o = 1'b1;
        repeat (3) @(negedge mclk_i);
    endtask
    task automatic free_sel;
        @(negedge mclk_i);
        strobe_n_o = 1'b0;
        repeat (3) @(negedge mclk_i);
    endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench of the host select block driven by a host model.
// Assumes the design package, header and host model are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %0t got %h exp %h", $time, g, e); end end

module tb_top;
    logic       mclk_i = 1'b0;
    logic       resetn_i = 1'b0;
    logic       cts_n_i = 1'b1;
    logic [7:0] tx_char_i = 8'h00;
    logic [2:0] rs, cs;
    logic       sl_n, rd_n, wr_n, oe, rck, tick, ten, mi, pe, pv, pb;
    logic [7:0] di, dq;
    logic [1:0] cl;
    int         error_cnt = 0;
    int         compares = 0;
    int         cyc = 0;
    localparam logic [2:0] SEL = 3'b110;
    // The board ties the receiver clock to the rate clock output.
    wire        rx_clk_tied = rck;
    uart_host_select dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .register_select_lines_i(rs), .select_latch_strobe_n_i(sl_n),
        .chip_select_high_a_i(cs[2]), .chip_select_high_b_i(cs[1]),
        .chip_select_low_n_i(cs[0]), .host_read_n_i(rd_n), .host_write_n_i(wr_n),
        .host_data_bus_i(di), .host_data_bus_o(dq), .host_data_bus_oe_o(oe),
        .cts_n_i(cts_n_i), .tx_char_i(tx_char_i), .tx_rate_clock_out_o(rck),
        .tx_rate_tick_o(tick), .tx_enable_o(ten), .modem_int_o(mi),
        .char_len_sel_o(cl), .parity_enable_o(pe), .parity_even_o(pv), .parity_bit_o(pb));
    host_cpu_model host_u (.mclk_i(mclk_i), .rdata_i(dq), .oe_i(oe), .addr_o(rs),
        .strobe_n_o(sl_n), .cs_o(cs), .rd_n_o(rd_n), .wr_n_o(wr_n), .wdata_o(di));
    initial begin
        forever #10 mclk_i = ~mclk_i;
    end
    task automatic close_out;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    // Expected parity over the character masked to its programmed length.
    function automatic logic par(input logic [7:0] c, input logic [1:0] n, input logic ev);
        logic [7:0] m;
        m = c & (8'hff >> (3 - n));
        return ev ? ^m : ~^m;
    endfunction
    initial begin
        logic [7:0] d, v;
        logic [7:0] dv[3];
        logic [2:0] bad[3];
        logic       s;
        int         p, h;
        d = $urandom(71750);
        bad = '{3'b111, 3'b100, 3'b010};
        repeat (10) @(negedge mclk_i);
        `CHK({oe, mi, ten, tick}, 4'b0010)
        resetn_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        host_u.rd(3'h3, SEL, d, s);
        `CHK({s, d}, 9'h100)
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom);
            host_u.wr(3'h7, SEL, v);
            host_u.rd(3'h7, SEL, d, s);
            `CHK({s, d}, {1'b1, v})
            host_u.wr(3'h7, bad[i % 3], ~v);
            host_u.rd(3'h7, bad[i % 3], d, s);
            `CHK(s, 1'b0)
            host_u.rd(3'h7, SEL, d, s);
            `CHK(d, v)
        end
        host_u.hold_sel(3'h7, SEL);
        host_u.rd(3'h2, 3'b001, d, s);
        `CHK({s, d}, {1'b1, v})
        host_u.free_sel();
        host_u.rd(3'h7, 3'b001, d, s);
        `CHK(s, 1'b0)
        for (int i = 0; i < 16; i++) begin
            host_u.wr(3'h3, SEL, {3'h0, i[3], i[2], 1'b0, i[1:0]});
            tx_char_i = 8'($urandom);
            @(negedge mclk_i);
            `CHK({cl, pe, pv}, {i[1:0], i[2], i[3]})
            if (i[2]) `CHK(pb, par(tx_char_i, i[1:0], i[3]))
            else `CHK(pb, 1'b0)
        end
        dv = '{8'h02, 8'h03 + 8'($urandom % 6), 8'h09};
        for (int k = 0; k < 3; k++) begin
            host_u.wr(3'h3, SEL, 8'h80);
            host_u.wr(3'h0, SEL, dv[k]);
            host_u.wr(3'h1, SEL, 8'h00);
            host_u.rd(3'h0, SEL, d, s);
            `CHK(d, dv[k])
            host_u.wr(3'h3, SEL, 8'h00);
            for (p = 0; p < 40 && tick !== 1'b1; p++) @(negedge mclk_i);
            p = 0;
            h = 0;
            do begin
                @(negedge mclk_i);
                p++;
                h += (rx_clk_tied === 1'b1);
            end while (tick !== 1'b1 && p < 40);
            `CHK(p, int'(dv[k]))
            `CHK(h, int'(dv[k] / 2))
        end
        host_u.wr(3'h1, SEL, 8'h08);
        host_u.wr(3'h4, SEL, 8'h00);
        host_u.rd(3'h6, SEL, d, s);
        for (int i = 0; i < 4; i++) begin
            if (i == 2) host_u.wr(3'h4, SEL, 8'h20);
            cts_n_i = ~cts_n_i;
            repeat (4) @(negedge mclk_i);
            `CHK(mi, i < 2)
            `CHK(ten, i < 2 || !cts_n_i)
            host_u.rd(3'h6, SEL, d, s);
            `CHK(d & 8'h11, {3'h0, ~cts_n_i, 3'h0, 1'b1})
            host_u.rd(3'h6, SEL, d, s);
            `CHK(d & 8'h11, {3'h0, ~cts_n_i, 4'h0})
        end
        close_out();
    end
endmodule
